// >>> lpm_pkg.sv
// constants and types shared by both ends of the low-power control link
// assumes a 100 MHz system clock on both ends and a host-made serial clock
package lpm_pkg;
	// ==========================================
	// serial frame
	localparam int FRAME_BITS = 16;
	localparam logic [7:0] KEY_ADDR = 8'h05;
	localparam logic [7:0] KEY_VALUE = 8'h69;
	localparam logic [7:0] PWRCTL_ADDR = 8'h04;
	localparam int LIGHT_BIT = 0;
	localparam int DEEP_BIT = 1;
	localparam logic [1:0] PWRCTL_RESET = 2'h0;
	// ==========================================
	// timing
	localparam int CLK_MHZ = 100;
	localparam int SCLK_HALF = 4;
	localparam int WAKE_TIME_NS = 400;
	localparam int PWRUP_TIME_NS = 2000;
	localparam int WAKE_CYC = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int PWRUP_CYC = (PWRUP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CONV_CYC = 50;
	// host slack over the device's two-flop sampling delay
	localparam int SYNC_MARGIN = 4;
	localparam int CNT_W = 12;
	// ==========================================
	// device power states
	typedef enum logic [2:0] {
		PS_ACQUISITION = 3'b000,
		PS_CONV = 3'b001,
		PS_LIGHT = 3'b011,
		PS_WAKE = 3'b010,
		PS_DEEP = 3'b110,
		PS_PWRUP = 3'b111
	} pstate_t;
	// host sequencing states
	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_SHIFT = 3'b001,
		HS_CONV = 3'b011,
		HS_WAIT = 3'b010
	} hstate_t;
	typedef enum logic [1:0] {
		CMD_WRITE = 2'h0,
		CMD_CONVERT = 2'h1,
		CMD_WAKE = 2'h2
	} cmd_t;
endpackage : lpm_pkg

// >>> lpm_link_if.sv
// serial configuration and convert/select link between host and converter
// assumes the host drives every wire but ready_indicator, which only the device drives
`timescale 1ns/1ps
interface lpm_link_if;
	logic sclk;
	logic sdi;
	logic convert_select_pin;
	logic ready_indicator;
	modport device_end (
		input sclk,
		input sdi,
		input convert_select_pin,
		output ready_indicator
	);
	modport host_end (
		output sclk,
		output sdi,
		output convert_select_pin,
		input ready_indicator
	);
endinterface : lpm_link_if

// >>> lpm_sync.sv
// two-flop synchroniser for one level from outside the clock domain
// assumes nothing about the input's timing
`timescale 1ns/1ps
module lpm_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic d,
	output logic q
);
	logic meta_r;
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			meta_r <= RESET_VALUE;
			q <= RESET_VALUE;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : lpm_sync

// >>> lpm_device.sv
// converter end: serial register decode and the power-state sequencer
// assumes the host drives sclk, sdi and convert_select_pin (frame low)
`timescale 1ns/1ps
module lpm_device (
	input wire logic CLK,
	input wire logic RESET_N,
	lpm_link_if.device_end link,
	output logic ANALOG_ON,
	output logic LIGHT_SLEEP_MODE,
	output logic DEEP_SLEEP_MODE,
	output logic [1:0] POWER_CONTROL,
	output logic UNLOCKED
);
	import lpm_pkg::*;
	// ==========================================
	// pin sampling
	logic sclk_s;
	logic sdi_s;
	logic cs_s;
	logic sclk_d_r;
	logic cs_d_r;
	lpm_sync #(.RESET_VALUE(1'b0)) u_sclk (.CLK(CLK), .RESET_N(RESET_N),
		.d(link.sclk), .q(sclk_s));
	lpm_sync #(.RESET_VALUE(1'b0)) u_sdi (.CLK(CLK), .RESET_N(RESET_N),
		.d(link.sdi), .q(sdi_s));
	// pin idles high: sampler resets high, else reset ends in a false rise
	lpm_sync #(.RESET_VALUE(1'b1)) u_cs (.CLK(CLK), .RESET_N(RESET_N),
		.d(link.convert_select_pin), .q(cs_s));
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			cs_d_r <= cs_s;
		end
	end
	logic sclk_rise;
	logic cs_rise;
	logic cs_fall;
	assign sclk_rise = sclk_s && !sclk_d_r;
	assign cs_rise = cs_s && !cs_d_r;
	assign cs_fall = !cs_s && cs_d_r;
	// ==========================================
	// serial frame capture, msb first: 8-bit address, 8-bit data
	logic [FRAME_BITS-1:0] shift_r;
	logic [4:0] bits_r;
	logic frame_done;
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			shift_r <= '0;
			bits_r <= '0;
		end
		else if (cs_s)
			bits_r <= '0;
		else if (sclk_rise)
		begin
			shift_r <= {shift_r[FRAME_BITS-2:0], sdi_s};
			bits_r <= bits_r + 5'h01;
		end
	end
	// a short frame is dropped silently; only full frames write
	assign frame_done = cs_rise && (bits_r == 5'(FRAME_BITS));
	logic [7:0] f_addr;
	logic [7:0] f_data;
	assign f_addr = shift_r[FRAME_BITS-1:8];
	assign f_data = shift_r[7:0];
	// ==========================================
	// unlock and power-control register
	logic unlock_r;
	logic [1:0] pwrctl_r;
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			unlock_r <= 1'b0;
		else if (frame_done)
			unlock_r <= (f_addr == KEY_ADDR) && (f_data == KEY_VALUE);
	end
	// register survives deep sleep: only reset or unlocked writes change it
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			pwrctl_r <= PWRCTL_RESET;
		else if (frame_done && f_addr == PWRCTL_ADDR && unlock_r)
			pwrctl_r <= {f_data[DEEP_BIT], f_data[LIGHT_BIT]};
	end
	logic light_en;
	logic deep_req;
	assign light_en = pwrctl_r[LIGHT_BIT];
	assign deep_req = pwrctl_r[DEEP_BIT];
	// ==========================================
	// power-state sequencer
	pstate_t ps_r;
	pstate_t ps_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	always_comb
	begin
		ps_nxt = ps_r;
		cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 12'h001;
		unique case (ps_r)
			// a frame's closing rise also starts a conversion, or enters deep sleep if deep_req is set
			PS_ACQUISITION:
				if (cs_rise && deep_req)
					ps_nxt = PS_DEEP;
				else if (cs_rise)
				begin
					ps_nxt = PS_CONV;
					cnt_nxt = CNT_W'(CONV_CYC);
				end
			PS_CONV:
				if (cnt_r == '0)
				begin
					if (light_en && cs_s)
						ps_nxt = PS_LIGHT;
					else
						ps_nxt = PS_ACQUISITION;
				end
			PS_LIGHT:
				if (cs_fall)
				begin
					ps_nxt = PS_WAKE;
					cnt_nxt = CNT_W'(WAKE_CYC);
				end
			PS_WAKE:
				if (cnt_r == '0)
					ps_nxt = PS_ACQUISITION;
			PS_DEEP:
				if (!deep_req)
				begin
					ps_nxt = PS_PWRUP;
					cnt_nxt = CNT_W'(PWRUP_CYC);
				end
			PS_PWRUP:
				if (cnt_r == '0)
					ps_nxt = PS_ACQUISITION;
			default:
				ps_nxt = PS_ACQUISITION;
		endcase
	end
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ps_r <= PS_ACQUISITION;
			cnt_r <= '0;
		end
		else
		begin
			ps_r <= ps_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// ==========================================
	// registered outputs
	// ready low only while converting or held in reset
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			link.ready_indicator <= 1'b0;
		else
			link.ready_indicator <= (ps_nxt != PS_CONV);
	end
	// supply and mode flags follow the next state, no extra cycle of lag
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ANALOG_ON <= 1'b1;
			LIGHT_SLEEP_MODE <= 1'b0;
			DEEP_SLEEP_MODE <= 1'b0;
		end
		else
		begin
			ANALOG_ON <= (ps_nxt != PS_DEEP);
			LIGHT_SLEEP_MODE <= (ps_nxt == PS_LIGHT);
			DEEP_SLEEP_MODE <= (ps_nxt == PS_DEEP);
		end
	end
	// register mirror
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			POWER_CONTROL <= PWRCTL_RESET;
			UNLOCKED <= 1'b0;
		end
		else
		begin
			POWER_CONTROL <= pwrctl_r;
			UNLOCKED <= unlock_r;
		end
	end
endmodule : lpm_device

// >>> lpm_host.sv
// host end: sends register frames, starts conversions, wakes the device
// assumes the device samples sclk and convert_select_pin on its own clock
`timescale 1ns/1ps
module lpm_host (
	input wire logic CLK,
	input wire logic RESET_N,
	lpm_link_if.host_end link,
	input wire logic CMD_VALID,
	input wire lpm_pkg::cmd_t CMD_KIND,
	input wire logic [7:0] CMD_ADDR,
	input wire logic [7:0] CMD_DATA,
	input wire logic CMD_WAIT_PWRUP,
	output logic CMD_READY,
	output logic READY_SEEN
);
	import lpm_pkg::*;
	logic rdy_s;
	lpm_sync u_rdy (.CLK(CLK), .RESET_N(RESET_N),
		.d(link.ready_indicator), .q(rdy_s));
	hstate_t hs_r;
	logic [FRAME_BITS-1:0] sh_r;
	logic [4:0] bit_r;
	logic [CNT_W-1:0] cnt_r;
	logic pend_r;
	// ==========================================
	// sequencer; sclk half period from a divider on CLK
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			hs_r <= HS_IDLE;
			sh_r <= '0;
			bit_r <= '0;
			cnt_r <= '0;
			pend_r <= 1'b0;
			link.sclk <= 1'b0;
			link.sdi <= 1'b0;
			link.convert_select_pin <= 1'b1;
			CMD_READY <= 1'b0;
		end
		else
		begin
			CMD_READY <= 1'b0;
			unique case (hs_r)
				HS_IDLE:
				begin
					CMD_READY <= !CMD_VALID;
					if (CMD_VALID && CMD_KIND == CMD_WRITE)
					begin
						sh_r <= {CMD_ADDR, CMD_DATA};
						bit_r <= '0;
						cnt_r <= CNT_W'(SCLK_HALF);
						pend_r <= CMD_WAIT_PWRUP;
						link.convert_select_pin <= 1'b0;
						link.sdi <= CMD_ADDR[7];
						hs_r <= HS_SHIFT;
					end
					else if (CMD_VALID && CMD_KIND == CMD_CONVERT)
					begin
						// pin rises to start; held high so the device may sleep
						link.convert_select_pin <= 1'b1;
						cnt_r <= CNT_W'(CONV_CYC + SYNC_MARGIN);
						hs_r <= HS_CONV;
					end
					else if (CMD_VALID)
					begin
						link.convert_select_pin <= 1'b0;
						cnt_r <= CNT_W'(WAKE_CYC + SYNC_MARGIN);
						hs_r <= HS_WAIT;
					end
				end
				HS_SHIFT:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 12'h001;
					else if (!link.sclk)
					begin
						link.sclk <= 1'b1;
						cnt_r <= CNT_W'(SCLK_HALF);
						bit_r <= bit_r + 5'h01;
					end
					else if (bit_r == 5'(FRAME_BITS))
					begin
						link.sclk <= 1'b0;
						link.convert_select_pin <= 1'b1;
						cnt_r <= pend_r ? CNT_W'(PWRUP_CYC + SYNC_MARGIN)
							: CNT_W'(SCLK_HALF);
						hs_r <= HS_WAIT;
					end
					else
					begin
						link.sclk <= 1'b0;
						link.sdi <= sh_r[FRAME_BITS-2];
						sh_r <= {sh_r[FRAME_BITS-2:0], 1'b0};
						cnt_r <= CNT_W'(SCLK_HALF);
					end
				HS_CONV:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 12'h001;
					else
						hs_r <= HS_IDLE;
				HS_WAIT:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 12'h001;
					else
						hs_r <= HS_IDLE;
				default:
					hs_r <= HS_IDLE;
			endcase
		end
	end
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			READY_SEEN <= 1'b0;
		else
			READY_SEEN <= rdy_s;
	end
endmodule : lpm_host

// >>> lpm_props.sv
// assertions on the host-device power link and device state
// assumes it is instantiated beside the link in the bench
`timescale 1ns/1ps
module lpm_props (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic convert_select_pin,
	input wire logic ready_indicator,
	input wire logic ANALOG_ON,
	input wire logic LIGHT_SLEEP_MODE,
	input wire logic DEEP_SLEEP_MODE,
	input wire logic [1:0] POWER_CONTROL,
	input wire logic UNLOCKED
);
	import lpm_pkg::*;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	// ==========================================
	// sequences
	sequence s_wake;
		$fell(convert_select_pin) && LIGHT_SLEEP_MODE;
	endsequence
	sequence s_go_deep;
		$rose(convert_select_pin) && POWER_CONTROL[DEEP_BIT];
	endsequence
	sequence s_held_light;
		convert_select_pin[*4] ##0 LIGHT_SLEEP_MODE;
	endsequence
	// ==========================================
	// properties
	property p_awake; !DEEP_SLEEP_MODE[*2] |-> ANALOG_ON; endproperty
	property p_lock; $changed(POWER_CONTROL) |-> $past(UNLOCKED); endproperty
	property p_enter_light;
		$rose(LIGHT_SLEEP_MODE) |->
			POWER_CONTROL[LIGHT_BIT] && convert_select_pin;
	endproperty
	property p_stay_light; s_held_light |=> LIGHT_SLEEP_MODE; endproperty
	property p_wake; s_wake |-> ##[1:6] !LIGHT_SLEEP_MODE; endproperty
	property p_deep; s_go_deep |-> ##[1:6] DEEP_SLEEP_MODE; endproperty
	property p_off; DEEP_SLEEP_MODE[*2] |-> !ANALOG_ON; endproperty
	property p_rdy; DEEP_SLEEP_MODE |-> ready_indicator; endproperty
	property p_pwrup; $fell(DEEP_SLEEP_MODE) |-> ready_indicator[*8];
	endproperty
	a_awake: assert property (p_awake)
		else $error("analog off outside deep sleep");
	a_lock: assert property (p_lock)
		else $error("power control changed while locked");
	a_enter_light: assert property (p_enter_light)
		else $error("light sleep entered wrongly");
	a_stay_light: assert property (p_stay_light)
		else $error("light sleep left with pin high");
	a_wake: assert property (p_wake)
		else $error("no wake on falling pin");
	a_deep: assert property (p_deep)
		else $error("deep sleep not entered");
	a_off: assert property (p_off)
		else $error("analog on in deep sleep");
	a_rdy: assert property (p_rdy)
		else $error("ready low in deep sleep");
	a_pwrup: assert property (p_pwrup)
		else $error("ready low at power-up");
endmodule : lpm_props

// >>> test_adc_low_power_mode_control.sv
// bench: host and converter ends joined by the link, host driven
// assumes lpm_pkg, lpm_link_if, lpm_sync and both ends compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
error_cnt++; $display("BAD %0t got %h want %h", $time, a, b); end end
module test_adc_low_power_mode_control;
	import lpm_pkg::*;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic cmd_valid = 1'b0;
	cmd_t cmd_kind = CMD_WRITE;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_wait = 1'b0;
	logic cmd_ready, analog_on, light, deep, unlocked, ready_seen;
	logic [1:0] pc;
	logic [1:0] exp_pc;
	logic [15:0] rnd = 16'h0fdd;
	int error_cnt = 0;
	int check_count = 0;
	time t0;
	lpm_link_if link_w();
	lpm_device i_lpm_device (.CLK(CLK), .RESET_N(RESET_N),
		.link(link_w.device_end), .ANALOG_ON(analog_on),
		.LIGHT_SLEEP_MODE(light), .DEEP_SLEEP_MODE(deep),
		.POWER_CONTROL(pc), .UNLOCKED(unlocked));
	lpm_host i_lpm_host (.CLK(CLK), .RESET_N(RESET_N),
		.link(link_w.host_end), .CMD_VALID(cmd_valid),
		.CMD_KIND(cmd_kind), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
		.CMD_WAIT_PWRUP(cmd_wait), .CMD_READY(cmd_ready),
		.READY_SEEN(ready_seen));
	lpm_props i_lpm_props (.CLK(CLK), .RESET_N(RESET_N),
		.convert_select_pin(link_w.convert_select_pin),
		.ready_indicator(link_w.ready_indicator), .ANALOG_ON(analog_on),
		.LIGHT_SLEEP_MODE(light), .DEEP_SLEEP_MODE(deep),
		.POWER_CONTROL(pc), .UNLOCKED(unlocked));
	always #5 CLK = ~CLK;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// a locked write leaves the old value
	function automatic logic [1:0] next_pc(input logic k,
		input logic [1:0] old, input logic [7:0] d);
		return k ? d[1:0] : old;
	endfunction : next_pc
	task automatic wrap_up;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic wait_ready;
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 4000)
		begin
			@(posedge CLK);
			#1;
			n++;
		end
		if (n >= 4000)
		begin
			error_cnt++;
			wrap_up();
		end
	endtask : wait_ready
	task automatic send(input cmd_t k, input logic [7:0] a,
		input logic [7:0] d, input logic w);
		wait_ready();
		@(posedge CLK);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_wait <= w;
		@(posedge CLK);
		cmd_valid <= 1'b0;
		@(posedge CLK);
		#1;
		wait_ready();
		repeat (8) @(posedge CLK);
		#1;
	endtask : send
	task automatic key;
		send(CMD_WRITE, KEY_ADDR, KEY_VALUE, 1'b0);
	endtask : key
	initial
	begin
		repeat (8) @(posedge CLK);
		RESET_N <= 1'b1;
		#1;
		`CHK(pc, PWRCTL_RESET)
		`CHK(analog_on, 1'b1)
		send(CMD_WRITE, PWRCTL_ADDR, 8'h01, 1'b0);
		`CHK(pc, 2'h0)
		// any full frame other than the key between key and write relocks
		key();
		`CHK(unlocked, 1'b1)
		send(CMD_WRITE, {2'h1, rnd[5:0]}, 8'h01, 1'b0);
		`CHK(unlocked, 1'b0)
		send(CMD_WRITE, PWRCTL_ADDR, 8'h01, 1'b0);
		`CHK(pc, 2'h0)
		exp_pc = 2'h0;
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			if (rnd[0])
				key();
			send(CMD_WRITE, PWRCTL_ADDR, {7'h00, rnd[1]}, 1'b0);
			exp_pc = next_pc(rnd[0], exp_pc, {7'h00, rnd[1]});
			`CHK(pc, exp_pc)
		end
		key();
		send(CMD_WRITE, PWRCTL_ADDR, 8'h01, 1'b0);
		`CHK(pc, 2'h1)
		// the write's closing rise converted already; drop the pin first
		repeat (60) @(posedge CLK);
		#1;
		send(CMD_WAKE, 8'h00, 8'h00, 1'b0);
		send(CMD_CONVERT, 8'h00, 8'h00, 1'b0);
		`CHK(light, 1'b1)
		`CHK(analog_on, 1'b1)
		t0 = $time;
		send(CMD_WAKE, 8'h00, 8'h00, 1'b0);
		`CHK(light, 1'b0)
		`CHK(($time - t0) >= WAKE_CYC * 10, 1'b1)
		key();
		send(CMD_WRITE, PWRCTL_ADDR, 8'h02, 1'b0);
		repeat (60) @(posedge CLK);
		#1;
		send(CMD_WAKE, 8'h00, 8'h00, 1'b0);
		send(CMD_CONVERT, 8'h00, 8'h00, 1'b0);
		`CHK(deep, 1'b1)
		`CHK(analog_on, 1'b0)
		`CHK(link_w.ready_indicator, 1'b1)
		`CHK(pc, 2'h2)
		`CHK(ready_seen, 1'b1)
		key();
		t0 = $time;
		send(CMD_WRITE, PWRCTL_ADDR, 8'h00, 1'b1);
		`CHK(deep, 1'b0)
		`CHK(link_w.ready_indicator, 1'b1)
		`CHK(($time - t0) >= PWRUP_CYC * 10, 1'b1)
		`CHK(analog_on, 1'b1)
		`CHK(ready_seen, 1'b1)
		wrap_up();
	end
endmodule : test_adc_low_power_mode_control
